// ### stp_coupler_model.sv
// process data source standing in for the bus coupler
`timescale 1ns/1ps
`default_nettype none
module stp_coupler_model #(
	parameter int PERIOD = 20
) (
	input wire logic sys_clk_in, // clock
	input wire logic rst_in, // sync reset, high
	input wire logic run_in, // cyclic exchange running
	output logic pd_strobe_out // one pulse per cycle of data
);
	int cnt;
	// silent while stopped, so the watchdog sees real gaps
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !run_in) begin
			cnt <= 0;
			pd_strobe_out <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			pd_strobe_out <= (cnt == PERIOD - 1);
		end
	end
endmodule
`default_nettype wire

// ### stp_map.svh
// register map, field positions, limits and timing constants of the stepper parameter bank
`ifndef STP_MAP_SVH
`define STP_MAP_SVH

`define STP_ADDR_W 8
`define STP_IDX_W 6
`define STP_NUM_PARAMS 13
`define STP_PIDX_W 4

`define STP_IDX_FEAT 6'h20
`define STP_IDX_STEPS 6'h21
`define STP_IDX_ENC 6'h22
`define STP_IDX_COIL_A 6'h23
`define STP_IDX_COIL_B 6'h24
`define STP_IDX_LATCH 6'h25
`define STP_IDX_VMIN 6'h26
`define STP_IDX_VMAX 6'h27
`define STP_IDX_AMAX 6'h28
`define STP_IDX_ATH 6'h29
`define STP_IDX_CUR_HI 6'h2A
`define STP_IDX_CUR_LO 6'h2B
`define STP_IDX_HOLD 6'h2C
`define STP_IDX_IRQ_STAT 6'h30
`define STP_IDX_IRQ_MASK 6'h31

`define STP_P_FEAT 4'h0
`define STP_P_STEPS 4'h1
`define STP_P_ENC 4'h2
`define STP_P_COIL_A 4'h3
`define STP_P_COIL_B 4'h4
`define STP_P_LATCH 4'h5
`define STP_P_VMIN 4'h6
`define STP_P_VMAX 4'h7
`define STP_P_AMAX 4'h8
`define STP_P_ATH 4'h9
`define STP_P_CUR_HI 4'hA
`define STP_P_CUR_LO 4'hB
`define STP_P_HOLD 4'hC

`define STP_RST_FEAT 16'h0000
`define STP_RST_STEPS 16'h00C8
`define STP_RST_ENC 16'h0FA0
`define STP_RST_COIL_LIMIT 16'h0064
`define STP_RST_LATCH 16'h0014
`define STP_RST_VMIN 16'h000A
`define STP_RST_LIMIT 16'h07FF
`define STP_RST_CUR 16'h0064
`define STP_RST_HOLD 16'h0032

`define STP_MAX_PCT 16'h0064
`define STP_MAX_LATCH 16'h0014
`define STP_MAX_VEL 16'h07FF
`define STP_FEAT_MASK 16'h00FF

`define STP_FB_CUR_TABLE 7
`define STP_FB_FLIP 6
`define STP_FB_RAMP 5
`define STP_FB_MODE_HI 4
`define STP_FB_MODE_LO 3
`define STP_FB_WD_OFF 2
`define STP_FB_HALT 1
`define STP_FB_LAUNCH 0

`define STP_IRQ_W 2
`define STP_IRQ_WDOG 0
`define STP_IRQ_CLAMP 1

`define STP_WD_TIMEOUT_MS 100
`define STP_CLK_KHZ 250000

`endif

// ### stp_param_bank.sv
// stepper drive user parameter bank with avalon slave and derived controls
// Operation
// - table select bit picks user or sine table
// - feedback flip bit inverts position feedback sign
// - ramp bit: exponential deceleration, path mode only
// - two-bit field selects one of four modes
// - watchdog fires after 100 ms without data
// - auto-halt active only when its bit set
// - auto-launch active only when its bit set
// - full steps per revolution, reset 200
// - encoder increments per revolution, reset 4000
// - per-winding current limit, 0 to 100 percent
// - latch value count, default and maximum 20
// - minimum velocity is direct stop cutoff
// - ramped modes never exceed maximum velocity
// - ramped modes limit acceleration to maximum
// - ramped modes compare acceleration with threshold
// - coil percent depends on threshold comparison
// - standstill reduces coils to holding percent
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.svh"
module stp_param_bank import stp_pkg::*; #(
	parameter int unsigned WD_CYCLES = `STP_WD_TIMEOUT_MS * `STP_CLK_KHZ
) (
	input wire logic sys_clk_in, // 250 MHz clock
	input wire logic rst_in, // sync reset, high
	input wire logic [`STP_ADDR_W-1:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall
	output logic irq_out, // level interrupt
	input wire logic pd_strobe_in, // process data arrived
	input wire logic [31:0] fb_pos_raw_in, // raw position feedback
	input wire logic [15:0] vel_cmd_in, // requested speed
	input wire logic [15:0] accel_cmd_in, // requested acceleration
	input wire logic [15:0] accel_now_in, // present acceleration
	input wire logic standstill_in, // motor stopped
	output logic [31:0] fb_pos_out, // signed feedback used
	output logic [15:0] vel_limited_out, // speed after limit
	output logic [15:0] accel_limited_out, // accel after limit
	output logic direct_stop_ok_out, // may stop without ramp
	output logic accel_over_out, // accel above threshold
	output logic [15:0] coil_pct_out, // coil current percent
	output logic [15:0] coil_a_limit_out, // winding a limit
	output logic [15:0] coil_b_limit_out, // winding b limit
	output logic [15:0] full_steps_out, // steps per turn
	output logic [15:0] enc_incs_out, // increments per turn
	output logic [15:0] latch_count_out, // latch values kept
	output logic current_table_select_out, // 1 user table
	output logic feedback_sign_flip_out, // feedback inverted
	output logic ramp_shape_select_out, // exponential bit
	output logic exp_decel_active_out, // exponential decel in use
	output var stp_mode_e motion_mode_select_out, // operating mode
	output logic watchdog_off_out, // watchdog disabled
	output logic wdog_expired_out, // watchdog tripped
	output logic auto_halt_enable_out, // auto stop on
	output logic auto_launch_enable_out // auto start on
);
	stp_word_t param_reg [0:`STP_NUM_PARAMS-1];
	logic [`STP_IRQ_W-1:0] irq_mask_reg;
	logic irq_stat_bit [0:`STP_IRQ_W-1];
	logic [`STP_IRQ_W-1:0] irq_stat;
	logic [`STP_IRQ_W-1:0] irq_event;
	logic ack_reg;
	logic [31:0] rd_value;
	logic [`STP_IDX_W-1:0] idx;
	logic [`STP_IDX_W-1:0] pdiff;
	logic [`STP_PIDX_W-1:0] pidx;
	logic rd_fire;
	logic wr_fire;
	logic param_wr;
	stp_word_t merged;
	stp_word_t clamped;
	stp_word_t feat;
	stp_mode_e mode_now;
	logic ramped;
	logic over_now;
	logic wd_pulse;
	logic wd_expired;

	function automatic logic param_hit(input logic [`STP_IDX_W-1:0] i);
		param_hit = i >= `STP_IDX_FEAT && i <= `STP_IDX_HOLD;
	endfunction

	function automatic stp_word_t reset_val(input logic [`STP_PIDX_W-1:0] p);
		case (p)
			`STP_P_FEAT: reset_val = `STP_RST_FEAT;
			`STP_P_STEPS: reset_val = `STP_RST_STEPS;
			`STP_P_ENC: reset_val = `STP_RST_ENC;
			`STP_P_COIL_A, `STP_P_COIL_B: reset_val = `STP_RST_COIL_LIMIT;
			`STP_P_LATCH: reset_val = `STP_RST_LATCH;
			`STP_P_VMIN: reset_val = `STP_RST_VMIN;
			`STP_P_CUR_HI, `STP_P_CUR_LO: reset_val = `STP_RST_CUR;
			`STP_P_HOLD: reset_val = `STP_RST_HOLD;
			default: reset_val = `STP_RST_LIMIT;
		endcase
	endfunction

	// saturate each field at its allowed maximum, except the feature word, which is masked to its low byte
	function automatic stp_word_t clamp_val(input logic [`STP_PIDX_W-1:0] p, input stp_word_t v);
		stp_word_t lim;
		lim = 16'hFFFF;
		case (p)
			`STP_P_COIL_A, `STP_P_COIL_B, `STP_P_CUR_HI, `STP_P_CUR_LO, `STP_P_HOLD: lim = `STP_MAX_PCT;
			`STP_P_LATCH: lim = `STP_MAX_LATCH;
			`STP_P_VMIN, `STP_P_VMAX, `STP_P_AMAX, `STP_P_ATH: lim = `STP_MAX_VEL;
			default: lim = 16'hFFFF;
		endcase
		if (p == `STP_P_FEAT) begin
			clamp_val = v & `STP_FEAT_MASK;
		end else begin
			clamp_val = (v > lim) ? lim : v;
		end
	endfunction

	function automatic stp_word_t be_merge(input stp_word_t old, input logic [15:0] wd, input logic [1:0] be);
		be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// bus handshake: one wait cycle, then answer
	assign idx = avs_address_in[`STP_ADDR_W-1:2];
	assign pdiff = idx - `STP_IDX_FEAT;
	assign pidx = pdiff[`STP_PIDX_W-1:0];
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
	assign rd_fire = avs_read_in && ack_reg;
	assign wr_fire = avs_write_in && ack_reg;
	assign param_wr = wr_fire && param_hit(idx);
	assign merged = be_merge(param_reg[pidx], avs_writedata_in[15:0], avs_byteenable_in[1:0]);
	assign clamped = clamp_val(pidx, merged);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
		end
	end

	always_comb begin
		rd_value = 32'h0000_0000;
		if (param_hit(idx)) begin
			rd_value = {16'h0000, param_reg[pidx]};
		end else if (idx == `STP_IDX_IRQ_STAT) begin
			rd_value[`STP_IRQ_W-1:0] = irq_stat;
		end else if (idx == `STP_IDX_IRQ_MASK) begin
			rd_value[`STP_IRQ_W-1:0] = irq_mask_reg;
		end
	end

	// sampled in the wait cycle, stable while waitrequest is low
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && !ack_reg) begin
			avs_readdata_out <= rd_value;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < `STP_NUM_PARAMS; i++) begin
				param_reg[i] <= reset_val(`STP_PIDX_W'(i));
			end
		end else if (param_wr) begin
			param_reg[pidx] <= clamped;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			irq_mask_reg <= '0;
		end else if (wr_fire && idx == `STP_IDX_IRQ_MASK) begin
			irq_mask_reg <= avs_writedata_in[`STP_IRQ_W-1:0];
		end
	end

	// sticky status, read clears only what was returned, set wins
	assign irq_event[`STP_IRQ_WDOG] = wd_pulse;
	assign irq_event[`STP_IRQ_CLAMP] = param_wr && clamped != merged;
	generate
		for (genvar g = 0; g < `STP_IRQ_W; g++) begin : g_stat
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					irq_stat_bit[g] <= 1'b0;
				end else if (irq_event[g]) begin
					irq_stat_bit[g] <= 1'b1;
				end else if (rd_fire && idx == `STP_IDX_IRQ_STAT && avs_readdata_out[g]) begin
					irq_stat_bit[g] <= 1'b0;
				end
			end
			assign irq_stat[g] = irq_stat_bit[g];
		end
	endgenerate
	assign irq_out = |(irq_stat & irq_mask_reg);

	stp_wdog #(
		.TIMEOUT_CYCLES(WD_CYCLES)
	) stp_wdog_i (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.enable_in(!feat[`STP_FB_WD_OFF]),
		.pd_strobe_in(pd_strobe_in),
		.timeout_pulse_out(wd_pulse),
		.expired_out(wd_expired)
	);

	// derived controls
	assign feat = param_reg[`STP_P_FEAT];
	assign mode_now = stp_mode_e'(feat[`STP_FB_MODE_HI:`STP_FB_MODE_LO]);
	assign ramped = mode_now == stp_mode_vel_ramp || mode_now == stp_mode_path;
	assign over_now = ramped && accel_now_in > param_reg[`STP_P_ATH];

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			current_table_select_out <= 1'b0;
			feedback_sign_flip_out <= 1'b0;
			ramp_shape_select_out <= 1'b0;
			exp_decel_active_out <= 1'b0;
			motion_mode_select_out <= stp_mode_vel_direct;
			watchdog_off_out <= 1'b0;
			wdog_expired_out <= 1'b0;
			auto_halt_enable_out <= 1'b0;
			auto_launch_enable_out <= 1'b0;
		end else begin
			current_table_select_out <= feat[`STP_FB_CUR_TABLE];
			feedback_sign_flip_out <= feat[`STP_FB_FLIP];
			ramp_shape_select_out <= feat[`STP_FB_RAMP];
			exp_decel_active_out <= feat[`STP_FB_RAMP] && mode_now == stp_mode_path;
			motion_mode_select_out <= mode_now;
			watchdog_off_out <= feat[`STP_FB_WD_OFF];
			wdog_expired_out <= wd_expired;
			auto_halt_enable_out <= feat[`STP_FB_HALT];
			auto_launch_enable_out <= feat[`STP_FB_LAUNCH];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fb_pos_out <= 32'h0000_0000;
		end else begin
			fb_pos_out <= feat[`STP_FB_FLIP] ? -fb_pos_raw_in : fb_pos_raw_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			full_steps_out <= `STP_RST_STEPS;
			enc_incs_out <= `STP_RST_ENC;
			latch_count_out <= `STP_RST_LATCH;
			coil_a_limit_out <= `STP_RST_COIL_LIMIT;
			coil_b_limit_out <= `STP_RST_COIL_LIMIT;
		end else begin
			full_steps_out <= param_reg[`STP_P_STEPS];
			enc_incs_out <= param_reg[`STP_P_ENC];
			latch_count_out <= param_reg[`STP_P_LATCH];
			coil_a_limit_out <= param_reg[`STP_P_COIL_A];
			coil_b_limit_out <= param_reg[`STP_P_COIL_B];
		end
	end

	// limits only bite in the ramped modes
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			vel_limited_out <= 16'h0000;
			accel_limited_out <= 16'h0000;
			direct_stop_ok_out <= 1'b0;
			accel_over_out <= 1'b0;
		end else begin
			vel_limited_out <= (ramped && vel_cmd_in > param_reg[`STP_P_VMAX]) ?
				param_reg[`STP_P_VMAX] : vel_cmd_in;
			accel_limited_out <= (ramped && accel_cmd_in > param_reg[`STP_P_AMAX]) ?
				param_reg[`STP_P_AMAX] : accel_cmd_in;
			direct_stop_ok_out <= ramped && vel_cmd_in <= param_reg[`STP_P_VMIN];
			accel_over_out <= over_now;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			coil_pct_out <= `STP_RST_CUR;
		end else if (standstill_in) begin
			coil_pct_out <= param_reg[`STP_P_HOLD];
		end else if (over_now) begin
			coil_pct_out <= param_reg[`STP_P_CUR_HI];
		end else begin
			coil_pct_out <= param_reg[`STP_P_CUR_LO];
		end
	end

	// checks
	property p_bus_answer;
		@(posedge sys_clk_in) disable iff (rst_in)
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	property p_cur_table;
		@(posedge sys_clk_in) disable iff (rst_in)
		wr_fire && idx == `STP_IDX_FEAT && avs_byteenable_in[0] |=> ##1
		current_table_select_out == $past(avs_writedata_in[`STP_FB_CUR_TABLE], 2);
	endproperty
	a_cur_table: assert property (p_cur_table) else $error("table select not applied");

	property p_fb_flip;
		@(posedge sys_clk_in) disable iff (rst_in)
		feat[`STP_FB_FLIP] |=> fb_pos_out == -$past(fb_pos_raw_in);
	endproperty
	a_fb_flip: assert property (p_fb_flip) else $error("feedback sign wrong");

	property p_exp_decel;
		@(posedge sys_clk_in) disable iff (rst_in)
		exp_decel_active_out |-> $past(mode_now) == stp_mode_path && $past(feat[`STP_FB_RAMP]);
	endproperty
	a_exp_decel: assert property (p_exp_decel) else $error("exponential ramp outside path mode");

	property p_mode;
		@(posedge sys_clk_in) disable iff (rst_in)
		##1 motion_mode_select_out == stp_mode_e'($past(feat[`STP_FB_MODE_HI:`STP_FB_MODE_LO]));
	endproperty
	a_mode: assert property (p_mode) else $error("mode field not followed");

	property p_wd_irq;
		@(posedge sys_clk_in) disable iff (rst_in)
		wd_pulse |=> irq_stat[`STP_IRQ_WDOG] ##1 wdog_expired_out || !$past(wd_expired, 1) || pd_strobe_in;
	endproperty
	a_wd_irq: assert property (p_wd_irq) else $error("watchdog event lost");

	property p_latch_max;
		@(posedge sys_clk_in) disable iff (rst_in)
		param_wr && pidx == `STP_P_LATCH && merged > `STP_MAX_LATCH |=> ##1 latch_count_out == `STP_MAX_LATCH;
	endproperty
	a_latch_max: assert property (p_latch_max) else $error("latch count not saturated");

	property p_coil_lim;
		@(posedge sys_clk_in) disable iff (rst_in)
		coil_a_limit_out <= `STP_MAX_PCT && coil_b_limit_out <= `STP_MAX_PCT;
	endproperty
	a_coil_lim: assert property (p_coil_lim) else $error("coil limit above full scale");

	property p_vel_max;
		@(posedge sys_clk_in) disable iff (rst_in)
		ramped && vel_cmd_in > param_reg[`STP_P_VMAX] |=> vel_limited_out == $past(param_reg[`STP_P_VMAX]);
	endproperty
	a_vel_max: assert property (p_vel_max) else $error("velocity limit exceeded");

	property p_acc_max;
		@(posedge sys_clk_in) disable iff (rst_in)
		ramped |=> accel_limited_out <= $past(param_reg[`STP_P_AMAX]);
	endproperty
	a_acc_max: assert property (p_acc_max) else $error("acceleration limit exceeded");

	property p_stop_cut;
		@(posedge sys_clk_in) disable iff (rst_in)
		direct_stop_ok_out |-> $past(ramped) && $past(vel_cmd_in) <= $past(param_reg[`STP_P_VMIN]);
	endproperty
	a_stop_cut: assert property (p_stop_cut) else $error("direct stop above cutoff");

	property p_over;
		@(posedge sys_clk_in) disable iff (rst_in)
		ramped && accel_now_in > param_reg[`STP_P_ATH] |=> accel_over_out;
	endproperty
	a_over: assert property (p_over) else $error("threshold compare missed");

	property p_hold;
		@(posedge sys_clk_in) disable iff (rst_in)
		standstill_in |=> coil_pct_out == $past(param_reg[`STP_P_HOLD]);
	endproperty
	a_hold: assert property (p_hold) else $error("holding current not applied");

	property p_run_pct;
		@(posedge sys_clk_in) disable iff (rst_in)
		!standstill_in && !over_now |=> coil_pct_out == $past(param_reg[`STP_P_CUR_LO]);
	endproperty
	a_run_pct: assert property (p_run_pct) else $error("low accel current wrong");

	c_read: cover property (@(posedge sys_clk_in) disable iff (rst_in) rd_fire && param_hit(idx));
	c_clamp: cover property (@(posedge sys_clk_in) disable iff (rst_in) irq_event[`STP_IRQ_CLAMP]);
	c_wdog: cover property (@(posedge sys_clk_in) disable iff (rst_in) wd_pulse ##1 irq_out);
	c_path: cover property (@(posedge sys_clk_in) disable iff (rst_in) exp_decel_active_out && accel_over_out);
endmodule
`default_nettype wire

// ### stp_pkg.sv
// types shared by the stepper parameter bank
`default_nettype none
package stp_pkg;
	typedef enum logic [1:0] {
		stp_mode_vel_direct,
		stp_mode_vel_ramp,
		stp_mode_pos_track,
		stp_mode_path
	} stp_mode_e;
	typedef logic [15:0] stp_word_t;
endpackage
`default_nettype wire

// ### stp_wdog.sv
// process data watchdog timer
`timescale 1ns/1ps
`default_nettype none
module stp_wdog #(
	parameter int unsigned TIMEOUT_CYCLES = 25000000
) (
	input wire logic sys_clk_in, // system clock
	input wire logic rst_in, // sync reset, high
	input wire logic enable_in, // watchdog armed
	input wire logic pd_strobe_in, // process data arrived
	output logic timeout_pulse_out, // one-cycle expiry event
	output logic expired_out // level until next data
);
	localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);
	logic [CW-1:0] count_reg;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !enable_in || pd_strobe_in) begin
			count_reg <= '0;
		end else if (!expired_out && count_reg != LAST) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !enable_in || pd_strobe_in) begin
			expired_out <= 1'b0;
			timeout_pulse_out <= 1'b0;
		end else begin
			timeout_pulse_out <= !expired_out && count_reg == LAST;
			if (count_reg == LAST) begin
				expired_out <= 1'b1;
			end
		end
	end

	property p_wd_fire;
		@(posedge sys_clk_in) disable iff (rst_in)
		timeout_pulse_out |-> $past(count_reg) == LAST && $past(enable_in) && !$past(pd_strobe_in);
	endproperty
	a_wd_fire: assert property (p_wd_fire) else $error("watchdog fired early or while off");

	property p_wd_quiet;
		@(posedge sys_clk_in) disable iff (rst_in)
		(pd_strobe_in || !enable_in) |=> !timeout_pulse_out && !expired_out;
	endproperty
	a_wd_quiet: assert property (p_wd_quiet) else $error("watchdog not restarted");
endmodule
`default_nettype wire

// ### tb_stepper_user_param_bank.sv
// self-checking testbench of the stepper parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "stp_map.svh"
module tb_stepper_user_param_bank import stp_pkg::*;;
	logic clk = 0, rst = 1, rd_r = 0, wr_r = 0, pd, stand = 0, run = 1, irq, wq;
	logic [7:0] addr = 0;
	logic [3:0] be = 4'hF;
	logic [31:0] wdat = 0, rdat, fb_raw = 32'h0000_0005, fb_o;
	logic [15:0] vel = 0, acc = 0, anow = 0, r;
	logic [15:0] vel_o, acc_o, pct_o, ca_o, cb_o, st_o, enc_o, lat_o;
	logic stop_o, over_o, tab_o, flip_o, ramp_o, exp_o, wdo_o, wde_o, halt_o, lau_o;
	stp_mode_e mode_o;
	int n_mismatch = 0, checks_done = 0;
	logic [15:0] rv [13] = '{16'h0000, 16'h00C8, 16'h0FA0, `STP_RST_COIL_LIMIT, `STP_RST_COIL_LIMIT,
		16'h0014, 16'h000A, 16'h07FF, 16'h07FF, 16'h07FF, 16'h0064, 16'h0064, 16'h0032};

	always #2 clk = ~clk;

	stp_coupler_model #(.PERIOD(20)) stp_coupler_model_i (.sys_clk_in(clk), .rst_in(rst), .run_in(run),
		.pd_strobe_out(pd));

	stp_param_bank #(.WD_CYCLES(50)) stp_param_bank_i (.sys_clk_in(clk), .rst_in(rst),
		.avs_address_in(addr), .avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .irq_out(irq),
		.pd_strobe_in(pd), .fb_pos_raw_in(fb_raw), .vel_cmd_in(vel), .accel_cmd_in(acc),
		.accel_now_in(anow), .standstill_in(stand), .fb_pos_out(fb_o), .vel_limited_out(vel_o),
		.accel_limited_out(acc_o), .direct_stop_ok_out(stop_o), .accel_over_out(over_o),
		.coil_pct_out(pct_o), .coil_a_limit_out(ca_o), .coil_b_limit_out(cb_o), .full_steps_out(st_o),
		.enc_incs_out(enc_o), .latch_count_out(lat_o), .current_table_select_out(tab_o),
		.feedback_sign_flip_out(flip_o), .ramp_shape_select_out(ramp_o), .exp_decel_active_out(exp_o),
		.motion_mode_select_out(mode_o), .watchdog_off_out(wdo_o), .wdog_expired_out(wde_o),
		.auto_halt_enable_out(halt_o), .auto_launch_enable_out(lau_o));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// one transfer, held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= {i, 2'b00};
		wr_r <= w;
		rd_r <= !w;
		wdat <= {16'h0000, d};
		do begin
			@(posedge clk);
			n++;
		end while (wq !== 1'b0);
		r = rdat[15:0];
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		chk("wait edges", 2, n);
	endtask

	task automatic st(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			bus(0, 6'h20 + 6'(i), 16'h0000);
			chk("reset value", rv[i], r);
		end
		st(1);
		chk("steps out", 200, st_o);
		chk("enc out", 4000, enc_o);
		chk("coil pct", 100, pct_o);
		$display("test reset done");

		bus(1, 6'h20, 16'hFFFF);
		bus(0, 6'h20, 16'h0000);
		chk("feature", 16'h00FF, r);
		st(3);
		chk("table", 1, tab_o);
		chk("flip", 1, flip_o);
		chk("fb pos", 32'hFFFF_FFFB, fb_o);
		chk("ramp", 1, ramp_o);
		chk("exp decel", 1, exp_o);
		chk("wd off", 1, wdo_o);
		chk("halt", 1, halt_o);
		chk("launch", 1, lau_o);
		$display("test features done");

		bus(1, 6'h27, 16'd100);
		bus(1, 6'h28, 16'd200);
		bus(1, 6'h29, 16'd50);
		bus(1, 6'h2A, 16'd80);
		bus(1, 6'h2B, 16'd30);
		vel <= 16'd150;
		acc <= 16'd300;
		anow <= 16'd51;
		for (int m = 0; m < 4; m++) begin
			bus(1, 6'h20, {8'h00, 3'h1, m[1:0], 3'h0});
			st(3);
			chk("mode", m[1:0], mode_o);
			chk("exp decel", m == 3, exp_o);
			chk("table", 0, tab_o);
			chk("fb pos", 5, fb_o);
			chk("halt", 0, halt_o);
			chk("launch", 0, lau_o);
			chk("vel lim", m[0] ? 100 : 150, vel_o);
			chk("acc lim", m[0] ? 200 : 300, acc_o);
			chk("over", m[0], over_o);
			chk("coil pct", m[0] ? 80 : 30, pct_o);
		end
		@(posedge clk);
		vel <= 16'd10;
		anow <= 16'd50;
		st(3);
		chk("stop ok", 1, stop_o);
		chk("over", 0, over_o);
		chk("coil pct", 30, pct_o);
		@(posedge clk);
		vel <= 16'd11;
		stand <= 1'b1;
		st(3);
		chk("stop ok", 0, stop_o);
		chk("coil pct", 50, pct_o);
		$display("test limits done");

		bus(1, 6'h31, 16'h0002);
		bus(1, 6'h23, 16'h0065);
		bus(1, 6'h25, 16'h0015);
		bus(1, 6'h26, 16'h0800);
		st(2);
		chk("irq", 1, irq);
		bus(0, 6'h30, 16'h0000);
		chk("status", 2, r);
		st(1);
		chk("irq", 0, irq);
		bus(0, 6'h23, 16'h0000);
		chk("coil a", 16'h0064, r);
		bus(0, 6'h25, 16'h0000);
		chk("latch", 16'h0014, r);
		bus(0, 6'h26, 16'h0000);
		chk("vmin", 16'h07FF, r);
		bus(1, 6'h24, 16'h0064);
		bus(1, 6'h21, 16'h0190);
		bus(1, 6'h22, 16'h1000);
		be <= 4'h2;
		bus(1, 6'h21, 16'hAB00);
		be <= 4'hF;
		bus(1, 6'h2D, 16'h1234);
		bus(0, 6'h2D, 16'h0000);
		chk("unmapped", 0, r);
		bus(0, 6'h30, 16'h0000);
		chk("status", 0, r);
		st(3);
		chk("coil a out", 16'h0064, ca_o);
		chk("coil b out", 16'h0064, cb_o);
		chk("steps out", 16'hAB90, st_o);
		chk("enc out", 16'h1000, enc_o);
		chk("latch out", 16'h0014, lat_o);
		$display("test saturation done");

		bus(1, 6'h31, 16'h0001);
		run <= 1'b0;
		st(25);
		chk("wd expired", 0, wde_o);
		st(40);
		chk("wd expired", 1, wde_o);
		chk("irq", 1, irq);
		bus(0, 6'h30, 16'h0000);
		chk("status", 1, r);
		run <= 1'b1;
		st(25);
		chk("wd expired", 0, wde_o);
		bus(1, 6'h20, 16'h0004);
		run <= 1'b0;
		st(80);
		chk("wd expired", 0, wde_o);
		chk("wd off", 1, wdo_o);
		bus(0, 6'h30, 16'h0000);
		chk("status", 0, r);
		$display("test watchdog done");
		end_sim();
	end
endmodule
`default_nettype wire
